// ==== rtl/gfl_pkg.sv ====
// constants shared by the rate sensor buffer and low-power configuration block
package gfl_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CAPACITY = 8'h1d;
  localparam logic [7:0] IDX_LOW_POWER = 8'h1e;
  localparam logic [7:0] IDX_SOURCE_EN = 8'h23;
  localparam logic [7:0] IDX_FRAME_SYNC_PIN_STATUS = 8'h36;
  localparam logic [7:0] IDX_CONTROL = 8'h40;
  localparam logic [7:0] IDX_LEVEL = 8'h41;
  // ----------------------------------------------------------------
  // field positions and writable masks
  // ----------------------------------------------------------------
  localparam int CAPACITY_LSB = 6;
  localparam int DUTY_CYCLE_BIT = 7;
  localparam int AVERAGING_LSB = 4;
  localparam int TEMP_PUSH_BIT = 7;
  localparam int X_RATE_PUSH_BIT = 6;
  localparam int Y_RATE_PUSH_BIT = 5;
  localparam int Z_RATE_PUSH_BIT = 4;
  localparam int FRAME_SYNC_PIN_FLAG_BIT = 7;
  localparam int CTRL_DIVIDER_LSB = 0;
  localparam int CTRL_POLICY_BIT = 8;
  localparam int CTRL_LOWPASS_LSB = 9;
  localparam logic [7:0] CAPACITY_MASK = 8'hc0;
  localparam logic [7:0] LOW_POWER_MASK = 8'hf0;
  localparam logic [7:0] SOURCE_EN_MASK = 8'hf0;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CAPACITY_RESET = 8'h00;
  localparam logic [7:0] LOW_POWER_RESET = 8'h00;
  localparam logic [7:0] SOURCE_EN_RESET = 8'h00;
  localparam logic [11:0] CONTROL_RESET = 12'h000;
  // ----------------------------------------------------------------
  // timing and sizes
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 25000000;
  localparam int INTERNAL_RATE_HZ = 1000;
  localparam int TICK_CYCLES = CLOCK_HZ / INTERNAL_RATE_HZ;
  localparam logic [12:0] CAPACITY_BASE_BYTES = 13'h0200;
  // ----------------------------------------------------------------
  // bus responses and sequencer states
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {GFL_IDLE, GFL_PUSH} gfl_state_t;
endpackage : gfl_pkg

// ==== rtl/gfl_config.sv ====
// sample buffer fifo and configuration register block with axi4-lite slave
//
// Implementation choice: the AXI4-Lite register port.

// ----------------------------------------------------------------
// byte fifo with usable limit and overwrite-oldest option
// ----------------------------------------------------------------
module gfl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic overwrite_in,
  input wire logic [AW:0] limit_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [AW:0] level_out
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] level_reg;
  logic full;
  logic push;
  logic pop;
  logic drop;

  assign full = (level_reg >= limit_in);
  assign push = in_valid_in && (!full || overwrite_in);
  assign pop = out_valid_out && out_ready_in;
  assign drop = push && full && !pop;
  assign in_ready_out = !full;
  assign out_valid_out = (level_reg != '0);
  assign out_data_out = mem[rd_ptr_reg];
  assign level_out = level_reg;

  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data_in;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      // overwrite drops the oldest entry to make room
      if (pop || drop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !(pop || drop))
        level_reg <= level_reg + 1'b1;
      else if (!push && pop)
        level_reg <= level_reg - 1'b1;
    end
  end
endmodule : gfl_fifo

// ----------------------------------------------------------------
// configuration, push sequencer and register slave
// ----------------------------------------------------------------
module gfl_config #(
  parameter int ADDR_W = 10,
  parameter int FIFO_DEPTH = 8,
  parameter int TICK_CYCLES = gfl_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [ADDR_W-1:0] awaddr_in,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [ADDR_W-1:0] araddr_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  input wire logic [15:0] temp_word_in,
  input wire logic [15:0] x_rate_word_in,
  input wire logic [15:0] y_rate_word_in,
  input wire logic [15:0] z_rate_word_in,
  input wire logic frame_sync_pin_in,
  output logic [7:0] buffer_data_out,
  output logic buffer_valid_out,
  input wire logic buffer_ready_in,
  output logic buffer_full_out,
  output logic sample_strobe_out,
  output logic duty_cycle_out,
  output logic [2:0] averaging_depth_out,
  output logic filter_from_averaging_out,
  output logic [2:0] rate_filter_code_out,
  output logic [12:0] buffer_capacity_bytes_out
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [7:0] capacity_reg;
  logic [7:0] low_power_reg;
  logic [7:0] source_en_reg;
  logic [11:0] control_reg;
  logic frame_sync_pin_flag_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] aw_index_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [7:0] ar_index;
  logic [2:0] sync_reg;
  logic pin_level_reg;
  logic [TW-1:0] tick_reg;
  logic [7:0] divide_reg;
  logic strobe_reg;
  gfl_pkg::gfl_state_t state_reg;
  logic [63:0] snap_reg;
  logic [3:0] push_en_reg;
  logic [2:0] byte_idx_reg;
  logic push_valid;
  logic fifo_in_ready;
  logic [AW:0] fifo_level;
  logic [AW:0] fifo_limit;
  logic [12:0] capacity_bytes;
  logic read_hit_frame_sync_pin;
  logic frame_sync_pin_event;
  logic commit_write;
  logic [32:0] aw_word;
  logic [32:0] ar_word;

  // unused low address bits carry byte position within the word
  assign ar_index = araddr_in[9:2];

  // ----------------------------------------------------------------
  // register read multiplexer
  // ----------------------------------------------------------------
  function automatic logic [32:0] read_word(input logic [7:0] index,
                                            input logic [AW:0] level);
    logic [32:0] r;
    r = '0;
    unique case (index)
      gfl_pkg::IDX_CAPACITY: r[7:0] = capacity_reg;
      gfl_pkg::IDX_LOW_POWER: r[7:0] = low_power_reg;
      gfl_pkg::IDX_SOURCE_EN: r[7:0] = source_en_reg;
      gfl_pkg::IDX_FRAME_SYNC_PIN_STATUS:
        r[gfl_pkg::FRAME_SYNC_PIN_FLAG_BIT] = frame_sync_pin_flag_reg;
      gfl_pkg::IDX_CONTROL: r[11:0] = control_reg;
      gfl_pkg::IDX_LEVEL: r[AW:0] = level;
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction : read_word

  assign aw_word = read_word(aw_index_reg, fifo_level);
  assign ar_word = read_word(ar_index, fifo_level);

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign commit_write = !awready_reg && !wready_reg && !bvalid_reg;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= gfl_pkg::RESP_OKAY;
      aw_index_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (awvalid_in && awready_reg)
      begin
        awready_reg <= 1'b0;
        aw_index_reg <= awaddr_in[9:2];
      end
      if (wvalid_in && wready_reg)
      begin
        wready_reg <= 1'b0;
        wdata_reg <= wdata_in;
        wstrb_reg <= wstrb_in;
      end
      if (commit_write)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= aw_word[32] ? gfl_pkg::RESP_SLVERR : gfl_pkg::RESP_OKAY;
      end
      if (bvalid_reg && bready_in)
      begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      capacity_reg <= gfl_pkg::CAPACITY_RESET;
      low_power_reg <= gfl_pkg::LOW_POWER_RESET;
      source_en_reg <= gfl_pkg::SOURCE_EN_RESET;
      control_reg <= gfl_pkg::CONTROL_RESET;
    end
    else if (commit_write && wstrb_reg[0])
    begin
      unique case (aw_index_reg)
        gfl_pkg::IDX_CAPACITY:
          capacity_reg <= wdata_reg[7:0] & gfl_pkg::CAPACITY_MASK;
        gfl_pkg::IDX_LOW_POWER:
          low_power_reg <= wdata_reg[7:0] & gfl_pkg::LOW_POWER_MASK;
        gfl_pkg::IDX_SOURCE_EN:
          source_en_reg <= wdata_reg[7:0] & gfl_pkg::SOURCE_EN_MASK;
        gfl_pkg::IDX_CONTROL:
        begin
          control_reg[7:0] <= wdata_reg[7:0];
          if (wstrb_reg[1])
            control_reg[11:8] <= wdata_reg[11:8];
        end
        default:
          control_reg <= control_reg;
      endcase
    end
    else if (commit_write && wstrb_reg[1] &&
             aw_index_reg == gfl_pkg::IDX_CONTROL)
      control_reg[11:8] <= wdata_reg[11:8];
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign read_hit_frame_sync_pin = arvalid_in && arready_reg &&
                          ar_index == gfl_pkg::IDX_FRAME_SYNC_PIN_STATUS;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= gfl_pkg::RESP_OKAY;
    end
    else if (arvalid_in && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= ar_word[31:0];
      rresp_reg <= ar_word[32] ? gfl_pkg::RESP_SLVERR : gfl_pkg::RESP_OKAY;
    end
    else if (rvalid_reg && rready_in)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // frame-sync pin synchroniser and status flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sync_reg <= 3'h0;
      pin_level_reg <= 1'b0;
    end
    else
    begin
      sync_reg <= {sync_reg[1:0], frame_sync_pin_in};
      if (sync_reg[1] == sync_reg[2])
        pin_level_reg <= sync_reg[2];
    end
  end

  assign frame_sync_pin_event = (sync_reg[1] == sync_reg[2]) && sync_reg[2] &&
                       !pin_level_reg;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      frame_sync_pin_flag_reg <= 1'b0;
    else if (frame_sync_pin_event)
      frame_sync_pin_flag_reg <= 1'b1;
    else if (read_hit_frame_sync_pin)
      frame_sync_pin_flag_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // sample strobe generator
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tick_reg <= '0;
      divide_reg <= 8'h00;
      strobe_reg <= 1'b0;
    end
    else
    begin
      strobe_reg <= 1'b0;
      if (tick_reg == TW'(TICK_CYCLES - 1))
      begin
        tick_reg <= '0;
        if (divide_reg >= control_reg[gfl_pkg::CTRL_DIVIDER_LSB +: 8])
        begin
          divide_reg <= 8'h00;
          strobe_reg <= 1'b1;
        end
        else
          divide_reg <= divide_reg + 8'h01;
      end
      else
        tick_reg <= tick_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // push sequencer
  // ----------------------------------------------------------------
  // standby of a measurement path is not consulted here
  assign push_valid = (state_reg == gfl_pkg::GFL_PUSH) &&
                      push_en_reg[3 - byte_idx_reg[2:1]];

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg <= gfl_pkg::GFL_IDLE;
      snap_reg <= 64'h0;
      push_en_reg <= 4'h0;
      byte_idx_reg <= 3'h0;
    end
    else
    begin
      unique case (state_reg)
        gfl_pkg::GFL_IDLE:
          if (strobe_reg && source_en_reg[7:4] != 4'h0)
          begin
            state_reg <= gfl_pkg::GFL_PUSH;
            snap_reg <= {temp_word_in, x_rate_word_in,
                         y_rate_word_in, z_rate_word_in};
            push_en_reg <= {source_en_reg[gfl_pkg::TEMP_PUSH_BIT],
                            source_en_reg[gfl_pkg::X_RATE_PUSH_BIT],
                            source_en_reg[gfl_pkg::Y_RATE_PUSH_BIT],
                            source_en_reg[gfl_pkg::Z_RATE_PUSH_BIT]};
            byte_idx_reg <= 3'h0;
          end
        gfl_pkg::GFL_PUSH:
        begin
          // discard policy drops on full; overwrite always accepts
          byte_idx_reg <= byte_idx_reg + 3'h1;
          if (byte_idx_reg == 3'h7)
            state_reg <= gfl_pkg::GFL_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sample buffer
  // ----------------------------------------------------------------
  assign capacity_bytes = gfl_pkg::CAPACITY_BASE_BYTES <<
                          capacity_reg[gfl_pkg::CAPACITY_LSB +: 2];
  assign fifo_limit = (capacity_bytes < 13'(FIFO_DEPTH)) ?
                      capacity_bytes[AW:0] : (AW + 1)'(FIFO_DEPTH);

  gfl_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(push_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(snap_reg[63 - 8 * byte_idx_reg -: 8]),
    .overwrite_in(!control_reg[gfl_pkg::CTRL_POLICY_BIT]),
    .limit_in(fifo_limit),
    .out_valid_out(buffer_valid_out),
    .out_ready_in(buffer_ready_in),
    .out_data_out(buffer_data_out),
    .level_out(fifo_level)
  );

  // ----------------------------------------------------------------
  // registered configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      buffer_full_out <= 1'b0;
      duty_cycle_out <= 1'b0;
      averaging_depth_out <= 3'h0;
      filter_from_averaging_out <= 1'b0;
      rate_filter_code_out <= 3'h0;
      buffer_capacity_bytes_out <= gfl_pkg::CAPACITY_BASE_BYTES;
    end
    else
    begin
      buffer_full_out <= !fifo_in_ready;
      duty_cycle_out <= low_power_reg[gfl_pkg::DUTY_CYCLE_BIT];
      averaging_depth_out <=
        low_power_reg[gfl_pkg::AVERAGING_LSB +: 3];
      filter_from_averaging_out <= low_power_reg[gfl_pkg::DUTY_CYCLE_BIT];
      rate_filter_code_out <= low_power_reg[gfl_pkg::DUTY_CYCLE_BIT] ?
        low_power_reg[gfl_pkg::AVERAGING_LSB +: 3] :
        control_reg[gfl_pkg::CTRL_LOWPASS_LSB +: 3];
      buffer_capacity_bytes_out <= capacity_bytes;
    end
  end

  assign awready_out = awready_reg;
  assign wready_out = wready_reg;
  assign bvalid_out = bvalid_reg;
  assign bresp_out = bresp_reg;
  assign arready_out = arready_reg;
  assign rvalid_out = rvalid_reg;
  assign rdata_out = rdata_reg;
  assign rresp_out = rresp_reg;
  assign sample_strobe_out = strobe_reg;
endmodule : gfl_config

// ==== test/gfl_config_checker.sv ====
// port checker for the configuration block
module gfl_config_checker (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic awvalid_in,
  input wire logic awready_out,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic bvalid_out,
  input wire logic bready_in,
  input wire logic [1:0] bresp_out,
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic rvalid_out,
  input wire logic rready_in,
  input wire logic [31:0] rdata_out,
  input wire logic buffer_valid_out,
  input wire logic buffer_full_out,
  input wire logic sample_strobe_out,
  input wire logic duty_cycle_out,
  input wire logic [2:0] averaging_depth_out,
  input wire logic filter_from_averaging_out,
  input wire logic [2:0] rate_filter_code_out,
  input wire logic [12:0] buffer_capacity_bytes_out
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence s_wr_take;
    awvalid_in && awready_out && wvalid_in && wready_out;
  endsequence
  sequence s_rd_take;
    arvalid_in && arready_out;
  endsequence
  a_write_answer: assert property (s_wr_take |-> ##2 bvalid_out)
    else $error("late bresp");
  a_read_answer: assert property (s_rd_take |=> rvalid_out)
    else $error("late rdata");
  a_bresp_holds: assert property (bvalid_out && !bready_in |=>
    bvalid_out && $stable(bresp_out))
    else $error("bresp dropped");
  a_rdata_holds: assert property (rvalid_out && !rready_in |=>
    rvalid_out && $stable(rdata_out))
    else $error("rdata dropped");
  a_filter_mirror: assert property (
    filter_from_averaging_out == duty_cycle_out)
    else $error("filter flag wrong");
  a_filter_source: assert property (
    duty_cycle_out |-> rate_filter_code_out == averaging_depth_out)
    else $error("filter code wrong");
  a_capacity_legal: assert property (
    buffer_capacity_bytes_out inside
    {13'h0200, 13'h0400, 13'h0800, 13'h1000})
    else $error("bad capacity");
  a_strobe_gap: assert property (
    sample_strobe_out |=> !sample_strobe_out [*8])
    else $error("strobes too close");
  a_full_has_data: assert property (
    buffer_full_out |-> buffer_valid_out)
    else $error("full but empty");
endmodule : gfl_config_checker

bind gfl_config gfl_config_checker gfl_config_checker_inst (.*);

// ==== test/gfl_host.sv ====
// host model reaching the registers over axi4-lite
module gfl_host (
  input wire logic clk_in,
  input wire logic slow_in,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [9:0] awaddr_out,
  output logic wvalid_out,
  input wire logic wready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  input wire logic bvalid_in,
  output logic bready_out,
  input wire logic [1:0] bresp_in,
  output logic arvalid_out,
  input wire logic arready_in,
  output logic [9:0] araddr_out,
  input wire logic rvalid_in,
  output logic rready_out,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in
);
  // ----------------------------------------------------------------
  // bus cycles, answered promptly or late as slow_in asks
  // ----------------------------------------------------------------
  initial
  begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h00;
    {awaddr_out, araddr_out, wdata_out, wstrb_out} = 56'h0;
  end
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge clk_in);
    awaddr_out <= {idx, 2'h0};
    wdata_out <= d;
    wstrb_out <= 4'hf;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= !slow_in;
    forever
    begin
      @(posedge clk_in);
      if (awvalid_out && awready_in)
        {awvalid_out, awaddr_out} <= {1'b0, ~awaddr_out};
      if (wvalid_out && wready_in)
        {wvalid_out, wdata_out} <= {1'b0, ~wdata_out};
      if (bready_out && bvalid_in)
      begin
        r = bresp_in;
        bready_out <= 1'b0;
        break;
      end
      bready_out <= bvalid_in || !slow_in;
    end
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge clk_in);
    araddr_out <= {idx, 2'h0};
    arvalid_out <= 1'b1;
    rready_out <= !slow_in;
    forever
    begin
      @(posedge clk_in);
      if (arvalid_out && arready_in)
        {arvalid_out, araddr_out} <= {1'b0, ~araddr_out};
      if (rready_out && rvalid_in)
      begin
        d = rdata_in;
        r = rresp_in;
        rready_out <= 1'b0;
        break;
      end
      rready_out <= rvalid_in || !slow_in;
    end
  endtask : rd
endmodule : gfl_host

// ==== test/tb_gfl_config.sv ====
// self-checking bench for the configuration block
module tb_gfl_config;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MASKS [6] = '{8'hf0, 8'h80, 8'h40, 8'h20, 8'h10, 0};
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic slow_in = 1'b0;
  logic awvalid_in, awready_out, wvalid_in, wready_out, bvalid_out, bready_in;
  logic arvalid_in, arready_out, rvalid_out, rready_in, frame_sync_pin_in;
  logic buffer_valid_out, buffer_ready_in, buffer_full_out, sample_strobe_out;
  logic duty_cycle_out, filter_from_averaging_out;
  logic [9:0] awaddr_in, araddr_in;
  logic [31:0] wdata_in, rdata_out;
  logic [3:0] wstrb_in;
  logic [1:0] bresp_out, rresp_out;
  logic [15:0] temp_word_in, x_rate_word_in, y_rate_word_in, z_rate_word_in;
  logic [7:0] buffer_data_out;
  logic [2:0] averaging_depth_out, rate_filter_code_out;
  logic [12:0] buffer_capacity_bytes_out;
  logic [15:0] rnd_reg = 16'h0057;
  logic [7:0] got[$];
  logic [7:0] exp_q[$];
  int fails = 0;
  int n_checks = 0;
  int since = 0;
  int gap = 0;
  // ----------------------------------------------------------------
  // clock, models, monitors and helpers
  // ----------------------------------------------------------------
  always #20 clk_in = ~clk_in;
  gfl_host gfl_host_inst (.clk_in, .slow_in, .awvalid_out(awvalid_in),
    .awready_in(awready_out), .awaddr_out(awaddr_in), .wvalid_out(wvalid_in),
    .wready_in(wready_out), .wdata_out(wdata_in), .wstrb_out(wstrb_in),
    .bvalid_in(bvalid_out), .bready_out(bready_in), .bresp_in(bresp_out),
    .arvalid_out(arvalid_in), .arready_in(arready_out),
    .araddr_out(araddr_in), .rvalid_in(rvalid_out), .rready_out(rready_in),
    .rdata_in(rdata_out), .rresp_in(rresp_out));
  gfl_config #(.TICK_CYCLES(10)) gfl_config_inst (.*);
  always @(posedge clk_in)
  begin
    if (buffer_valid_out === 1'b1 && buffer_ready_in)
      got.push_back(buffer_data_out);
    since <= (sample_strobe_out === 1'b1) ? 0 : since + 1;
    if (sample_strobe_out === 1'b1)
      gap <= since + 1;
  end
  function automatic logic [15:0] rnd();
    rnd_reg = {rnd_reg[14:0],
      rnd_reg[15] ^ rnd_reg[13] ^ rnd_reg[12] ^ rnd_reg[10]};
    return rnd_reg;
  endfunction : rnd
  function automatic void expect_bytes(input logic [7:0] m);
    logic [63:0] all;
    all = {temp_word_in, x_rate_word_in, y_rate_word_in, z_rate_word_in};
    exp_q.delete();
    for (int i = 0; i < 4; i++)
      if (m[7-i])
      begin
        exp_q.push_back(all[63-16*i -: 8]);
        exp_q.push_back(all[55-16*i -: 8]);
      end
  endfunction : expect_bytes
  task automatic check(input logic [31:0] seen, input logic [31:0] e);
    n_checks++;
    if (seen !== e)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, e);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic wreg(input logic [7:0] idx, input logic [31:0] d,
    input logic [1:0] er = gfl_pkg::RESP_OKAY);
    logic [15:0] v;
    logic [1:0] r;
    v = rnd();
    slow_in <= v[0];
    gfl_host_inst.wr(idx, d, r);
    check(32'(r), 32'(er));
  endtask : wreg
  task automatic rchk(input logic [7:0] idx, input logic [31:0] e,
    input logic [1:0] er = gfl_pkg::RESP_OKAY);
    logic [15:0] v;
    logic [31:0] d;
    logic [1:0] r;
    v = rnd();
    slow_in <= v[0];
    gfl_host_inst.rd(idx, d, r);
    check(32'(r), 32'(er));
    check(d, e);
  endtask : rchk
  task automatic wait_strobe();
    for (int i = 0; i < 100; i++)
    begin
      @(posedge clk_in);
      if (sample_strobe_out === 1'b1)
        return;
    end
    fails++;
    tally_and_finish();
  endtask : wait_strobe
  task automatic new_words();
    temp_word_in <= rnd();
    x_rate_word_in <= rnd();
    y_rate_word_in <= rnd();
    z_rate_word_in <= rnd();
  endtask : new_words
  task automatic cmp_q();
    check(32'(got.size()), 32'(exp_q.size()));
    foreach (exp_q[i])
      check(32'(got[i]), 32'(exp_q[i]));
  endtask : cmp_q
  initial
  begin
    repeat (20000) @(posedge clk_in);
    fails++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin : main
    logic [15:0] v;
    logic [7:0] m;
    frame_sync_pin_in = 1'b0;
    buffer_ready_in = 1'b1;
    {temp_word_in, x_rate_word_in, y_rate_word_in, z_rate_word_in} = 64'h0;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rchk(gfl_pkg::IDX_CAPACITY, 32'h0);
    rchk(gfl_pkg::IDX_LOW_POWER, 32'h0);
    rchk(gfl_pkg::IDX_SOURCE_EN, 32'h0);
    rchk(gfl_pkg::IDX_FRAME_SYNC_PIN_STATUS, 32'h0);
    check(32'(buffer_capacity_bytes_out), 32'h200);
    $display("test reset values done");
    for (int c = 0; c < 4; c++)
    begin
      v = rnd();
      wreg(gfl_pkg::IDX_CAPACITY, {24'h0, c[1:0], v[5:0]});
      rchk(gfl_pkg::IDX_CAPACITY, {24'h0, c[1:0], 6'h00});
      check(32'(buffer_capacity_bytes_out), 32'h200 << c);
    end
    wreg(gfl_pkg::IDX_CONTROL, 32'h0000_0a00);
    for (int n = 0; n < 8; n++)
    begin
      wreg(gfl_pkg::IDX_LOW_POWER, {24'h0, 1'b1, n[2:0], 4'hf});
      rchk(gfl_pkg::IDX_LOW_POWER, {24'h0, 1'b1, n[2:0], 4'h0});
      check(32'(duty_cycle_out), 32'h1);
      check(32'(averaging_depth_out), 32'(n));
      check(32'(rate_filter_code_out), 32'(n));
    end
    wreg(gfl_pkg::IDX_LOW_POWER, 32'h70);
    rchk(gfl_pkg::IDX_LOW_POWER, 32'h70);
    check(32'(duty_cycle_out), 32'h0);
    check(32'(rate_filter_code_out), 32'h5);
    $display("test low power done");
    wreg(8'h00, 32'hffff_ffff, gfl_pkg::RESP_SLVERR);
    rchk(8'h3f, 32'h0, gfl_pkg::RESP_SLVERR);
    $display("test unmapped done");
    frame_sync_pin_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    frame_sync_pin_in <= 1'b0;
    rchk(gfl_pkg::IDX_FRAME_SYNC_PIN_STATUS, 32'h80);
    rchk(gfl_pkg::IDX_FRAME_SYNC_PIN_STATUS, 32'h0);
    $display("test frame sync done");
    wreg(gfl_pkg::IDX_CONTROL, 32'h0000_0b01);
    for (int i = 0; i < 9; i++)
    begin
      v = rnd();
      m = (i < 6) ? MASKS[i] : {v[7:4], 4'h0};
      new_words();
      wreg(gfl_pkg::IDX_SOURCE_EN, {24'h0, m[7:4], v[3:0]});
      rchk(gfl_pkg::IDX_SOURCE_EN, {24'h0, m});
      wait_strobe();
      repeat (14) @(posedge clk_in);
      got.delete();
      wait_strobe();
      repeat (14) @(posedge clk_in);
      check(32'(gap), 32'd20);
      expect_bytes(m);
      cmp_q();
    end
    $display("test stream done");
    for (int p = 0; p < 2; p++)
    begin
      wreg(gfl_pkg::IDX_CONTROL, {20'h0, 3'h5, p[0], 8'h03});
      wreg(gfl_pkg::IDX_SOURCE_EN, 32'hf0);
      wait_strobe();
      repeat (14) @(posedge clk_in);
      buffer_ready_in <= 1'b0;
      wait_strobe();
      repeat (14) @(posedge clk_in);
      check(32'(gap), 32'd40);
      if (p == 1)
        expect_bytes(8'hf0);
      new_words();
      wait_strobe();
      repeat (14) @(posedge clk_in);
      if (p == 0)
        expect_bytes(8'hf0);
      wreg(gfl_pkg::IDX_SOURCE_EN, 32'h0);
      check(32'(buffer_full_out), 32'h1);
      got.delete();
      buffer_ready_in <= 1'b1;
      repeat (12) @(posedge clk_in);
      cmp_q();
    end
    $display("test full policy done");
    tally_and_finish();
  end
endmodule : tb_gfl_config
